// ---- ofd_regs.svh ----
// Register offsets, field positions, reset values and timing for the operand decoder
// Assumes a 32-bit Avalon-MM slave with word addressing
`ifndef OFD_REGS_SVH
`define OFD_REGS_SVH

// ****************************************
// Register word indices
// ****************************************
`define OFD_REG_BANK    3'h0
`define OFD_REG_FLAGS   3'h1
`define OFD_REG_PROD    3'h2
`define OFD_REG_TABLE_POINTER  3'h3
`define OFD_REG_LAST    3'h4

// ****************************************
// Reset values and widths
// ****************************************
`define OFD_BANK_W      4
`define OFD_BANK_RST    4'h0
`define OFD_FLAGS_RST   5'h00
`define OFD_PROD_RST    16'h0000
`define OFD_TABLE_POINTER_RST  21'h00_0000
`define OFD_TABLE_POINTER_W    21

// ****************************************
// Instruction word field positions
// ****************************************
`define OFD_A_BIT       8
`define OFD_D_BIT       9
`define OFD_S_BIT       0
`define OFD_TOP_NIB     4'hF

// ****************************************
// Timing
// ****************************************
`define OFD_CLK_PER_CYC 4

`endif

// ---- ofd_pkg.sv ----
// Types shared by the operand decoder and its table pointer unit
// Assumes nothing beyond a SystemVerilog compiler
package ofd_pkg;

  typedef enum logic [1:0] {
    OFD_ST_SINGLE = 2'b00,
    OFD_ST_SECOND = 2'b01,
    OFD_ST_FLUSH  = 2'b10
  } ofd_state_t;

  typedef enum logic [1:0] {
    OFD_STEP_NONE = 2'b00,
    OFD_STEP_POSTINC = 2'b01,
    OFD_STEP_POSTDEC = 2'b10,
    OFD_STEP_PREINC  = 2'b11
  } ofd_step_t;

endpackage : ofd_pkg

// ---- ofd_table_pointer.sv ----
// Table pointer with the four step modes
// Assumes load and step come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "ofd_regs.svh"

module ofd_table_pointer (
  input  wire logic                     clock_in,
  input  wire logic                     rst_b_in,
  input  wire logic                     load_in,
  input  wire logic [`OFD_TABLE_POINTER_W-1:0] load_val_in,
  input  wire logic                     step_in,
  input  wire ofd_pkg::ofd_step_t       mode_in,
  output logic      [`OFD_TABLE_POINTER_W-1:0] ptr_out,
  output logic      [`OFD_TABLE_POINTER_W-1:0] access_addr_out
);
  import ofd_pkg::*;

  logic [`OFD_TABLE_POINTER_W-1:0] ptr_q;
  logic [`OFD_TABLE_POINTER_W-1:0] acc_q;
  logic [`OFD_TABLE_POINTER_W-1:0] inc_w;
  logic [`OFD_TABLE_POINTER_W-1:0] dec_w;

  assign inc_w = ptr_q + 21'h00_0001;
  assign dec_w = ptr_q - 21'h00_0001;
  assign ptr_out = ptr_q;
  assign access_addr_out = acc_q;

  // ****************************************
  // Pointer update, step wins over load
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ptr_q <= `OFD_TABLE_POINTER_RST;
      acc_q <= `OFD_TABLE_POINTER_RST;
    end else if (step_in) begin
      case (mode_in)
        OFD_STEP_NONE:    begin ptr_q <= ptr_q; acc_q <= ptr_q; end
        OFD_STEP_POSTINC: begin ptr_q <= inc_w; acc_q <= ptr_q; end
        OFD_STEP_POSTDEC: begin ptr_q <= dec_w; acc_q <= ptr_q; end
        OFD_STEP_PREINC:  begin ptr_q <= inc_w; acc_q <= inc_w; end
        default:          begin ptr_q <= ptr_q; acc_q <= ptr_q; end
      endcase
    end else if (load_in) begin
      ptr_q <= load_val_in;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_tbl_post;
    @(posedge clock_in) disable iff (!rst_b_in)
      step_in && mode_in == OFD_STEP_POSTINC |=>
        ptr_q == $past(ptr_q) + 21'h00_0001 && acc_q == $past(ptr_q);
  endproperty
  a_tbl_post: assert property (p_tbl_post) else $error("post-increment wrong");

  property p_tbl_pre;
    @(posedge clock_in) disable iff (!rst_b_in)
      step_in && mode_in == OFD_STEP_PREINC |=> acc_q == ptr_q && acc_q != $past(ptr_q);
  endproperty
  a_tbl_pre: assert property (p_tbl_pre) else $error("pre-increment wrong");

endmodule : ofd_table_pointer
`default_nettype wire

// ---- ofd_decoder.sv ----
// Operand field decoder with Avalon-MM register slave
// Assumes instruction words and datapath strobes arrive on clock_in
`timescale 1ns/1ps
`default_nettype none
`include "ofd_regs.svh"

module ofd_decoder (
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  input  wire logic [2:0]       avs_address_in,
  input  wire logic             avs_read_in,
  input  wire logic             avs_write_in,
  input  wire logic [31:0]      avs_writedata_in,
  input  wire logic [3:0]       avs_byteenable_in,
  output logic      [31:0]      avs_readdata_out,
  output logic                  avs_waitrequest_out,
  input  wire logic [15:0]      instr_word_in,
  input  wire logic             instr_valid_in,
  input  wire logic             taken_in,
  input  wire logic             flags_we_in,
  input  wire logic [4:0]       flags_in,
  input  wire logic             prod_we_in,
  input  wire logic [15:0]      prod_in,
  output logic                  cycle_start_out,
  output logic                  access_ram_out,
  output logic [`OFD_BANK_W-1:0] ram_bank_out,
  output logic [7:0]            file_addr_out,
  output logic                  dest_file_out,
  output logic [7:0]            bit_onehot_out,
  output logic [1:0]            ptr_sel_out,
  output logic [11:0]           src_addr_out,
  output logic [11:0]           dst_addr_out,
  output logic [6:0]            src_off_out,
  output logic [6:0]            dst_off_out,
  output logic [7:0]            lit8_out,
  output logic [11:0]           lit12_out,
  output logic [19:0]           lit20_out,
  output logic [10:0]           rel_off_out,
  output logic                  fast_out,
  output logic                  exec_nop_out,
  output logic [20:0]           tbl_addr_out,
  output logic [4:0]            flags_out,
  output logic [7:0]            product_high_byte_out,
  output logic [7:0]            product_low_byte_out
);
  import ofd_pkg::*;

  // ****************************************
  // Instruction cycle enable
  // ****************************************
  logic [1:0] qcnt_q;
  logic       q_en;
  logic       cyc_q;

  assign q_en = (qcnt_q == 2'(`OFD_CLK_PER_CYC - 1));

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      qcnt_q <= 2'h0;
      cyc_q  <= 1'b0;
    end else begin
      qcnt_q <= qcnt_q + 2'h1;
      cyc_q  <= q_en;
    end
  end
  assign cycle_start_out = cyc_q;

  // ****************************************
  // Opcode class decode
  // ****************************************
  ofd_state_t state_q;
  logic [15:0] w;
  logic [15:0] w1_q;
  logic        lat;
  logic        is_movff;
  logic        is_goto;
  logic        is_call;
  logic        is_lfsr;
  logic        is_two;
  logic        is_tbl;
  logic        is_ret;
  logic        is_bra;
  logic        is_bcc;
  logic        first;
  logic        second;

  assign w        = instr_word_in;
  assign lat      = q_en && instr_valid_in;
  assign first    = lat && state_q == OFD_ST_SINGLE;
  assign second   = lat && state_q == OFD_ST_SECOND;
  assign is_movff = w[15:12] == 4'hC;
  assign is_goto  = w[15:8] == 8'hEF;
  assign is_call  = w[15:9] == 7'h76;
  assign is_lfsr  = w[15:6] == 10'h3B8;
  assign is_two   = is_movff || is_goto || is_call || is_lfsr;
  assign is_tbl   = w[15:3] == 13'h0001;
  assign is_ret   = w[15:1] == 15'h0009 || w[15:1] == 15'h0008;
  assign is_bra   = w[15:12] == 4'hD;
  assign is_bcc   = w[15:11] == 5'h1C;

  // ****************************************
  // Sequencing of two-word and taken cycles
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_q <= OFD_ST_SINGLE;
    end else if (q_en) begin
      case (state_q)
        OFD_ST_SINGLE: begin
          if (lat && is_two && w[15:12] != `OFD_TOP_NIB) begin
            state_q <= OFD_ST_SECOND;
          end else if (taken_in) begin
            state_q <= OFD_ST_FLUSH;
          end
        end
        OFD_ST_SECOND: begin
          if (lat) begin
            state_q <= taken_in ? OFD_ST_FLUSH : OFD_ST_SINGLE;
          end
        end
        OFD_ST_FLUSH: begin
          state_q <= OFD_ST_SINGLE;
        end
        default: begin
          state_q <= OFD_ST_SINGLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      w1_q <= 16'h0000;
    end else if (first) begin
      w1_q <= w;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  logic [`OFD_BANK_W-1:0] bank_select_reg_q;
  logic [4:0]             flags_q;
  logic [15:0]            prod_q;
  logic                   wait_q;
  logic                   wr_go;
  logic [31:0]            bmask;
  logic [31:0]            wmerge;
  logic [20:0]            tbl_ptr;
  logic [20:0]            tbl_acc;
  logic [31:0]            rd_d;

  assign wr_go = avs_write_in && !wait_q;
  assign bmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                  {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  always_comb begin
    case (avs_address_in)
      `OFD_REG_BANK:   wmerge = {28'h000_0000, bank_select_reg_q};
      `OFD_REG_FLAGS:  wmerge = {27'h000_0000, flags_q};
      `OFD_REG_PROD:   wmerge = {16'h0000, prod_q};
      `OFD_REG_TABLE_POINTER: wmerge = {11'h000, tbl_ptr};
      default:         wmerge = 32'h0000_0000;
    endcase
    wmerge = (wmerge & ~bmask) | (avs_writedata_in & bmask);
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      bank_select_reg_q <= `OFD_BANK_RST;
    end else if (wr_go && avs_address_in == `OFD_REG_BANK) begin
      bank_select_reg_q <= wmerge[`OFD_BANK_W-1:0];
    end
  end

  // Hardware updates win over a software write in the same cycle
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      flags_q <= `OFD_FLAGS_RST;
    end else if (flags_we_in) begin
      flags_q <= flags_in;
    end else if (wr_go && avs_address_in == `OFD_REG_FLAGS) begin
      flags_q <= wmerge[4:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      prod_q <= `OFD_PROD_RST;
    end else if (prod_we_in) begin
      prod_q <= prod_in;
    end else if (wr_go && avs_address_in == `OFD_REG_PROD) begin
      prod_q <= wmerge[15:0];
    end
  end
  assign flags_out             = flags_q;
  assign product_high_byte_out = prod_q[15:8];
  assign product_low_byte_out  = prod_q[7:0];

  always_comb begin
    case (avs_address_in)
      `OFD_REG_BANK:   rd_d = {28'h000_0000, bank_select_reg_q};
      `OFD_REG_FLAGS:  rd_d = {27'h000_0000, flags_q};
      `OFD_REG_PROD:   rd_d = {16'h0000, prod_q};
      `OFD_REG_TABLE_POINTER: rd_d = {11'h000, tbl_ptr};
      `OFD_REG_LAST:   rd_d = {14'h0000, state_q, w1_q};
      default:         rd_d = 32'h0000_0000;
    endcase
  end

  // Every access answers one cycle after it is first seen
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      wait_q           <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if (avs_read_in || avs_write_in) begin
      wait_q           <= 1'b0;
      avs_readdata_out <= avs_read_in ? rd_d : 32'h0000_0000;
    end
  end
  assign avs_waitrequest_out = wait_q;

  // ****************************************
  // Table pointer unit
  // ****************************************
  ofd_table_pointer u_tbl (
    .clock_in        (clock_in),
    .rst_b_in        (rst_b_in),
    .load_in         (wr_go && avs_address_in == `OFD_REG_TABLE_POINTER),
    .load_val_in     (wmerge[20:0]),
    .step_in         (first && is_tbl),
    .mode_in         (ofd_step_t'(w[1:0])),
    .ptr_out         (tbl_ptr),
    .access_addr_out (tbl_acc)
  );
  assign tbl_addr_out = tbl_acc;

  // ****************************************
  // Bit position select
  // ****************************************
  logic [7:0] bit_d;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      assign bit_d[gi] = (w[11:9] == 3'(gi));
    end
  endgenerate

  // ****************************************
  // Operand field registers
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      access_ram_out <= 1'b0;
      ram_bank_out   <= `OFD_BANK_RST;
      file_addr_out  <= 8'h00;
      dest_file_out  <= 1'b0;
      bit_onehot_out <= 8'h01;
      ptr_sel_out    <= 2'h0;
      lit8_out       <= 8'h00;
      rel_off_out    <= 11'h000;
      fast_out       <= 1'b0;
      src_off_out    <= 7'h00;
    end else if (first) begin
      access_ram_out <= !w[`OFD_A_BIT];
      ram_bank_out   <= w[`OFD_A_BIT] ? bank_select_reg_q : `OFD_BANK_RST;
      file_addr_out  <= w[7:0];
      dest_file_out  <= w[`OFD_D_BIT];
      bit_onehot_out <= bit_d;
      ptr_sel_out    <= w[5:4];
      lit8_out       <= w[7:0];
      rel_off_out    <= is_bcc ? {{3{w[7]}}, w[7:0]} : w[10:0];
      // A call carries its fast bit next to the target byte, a return in bit 0
      fast_out       <= is_call ? w[8] : (is_ret && w[`OFD_S_BIT]);
      src_off_out    <= w[6:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      src_addr_out <= 12'h000;
      dst_addr_out <= 12'h000;
      dst_off_out  <= 7'h00;
      lit12_out    <= 12'h000;
      lit20_out    <= 20'h0_0000;
    end else if (second) begin
      src_addr_out <= w1_q[11:0];
      dst_addr_out <= w[11:0];
      dst_off_out  <= w[6:0];
      lit12_out    <= {w1_q[3:0], w[7:0]};
      lit20_out    <= {w[11:0], w1_q[7:0]};
    end
  end

  // Don't-care bits never reach a decision, and a lone second word is a no-op
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      exec_nop_out <= 1'b0;
    end else if (q_en) begin
      exec_nop_out <= state_q == OFD_ST_FLUSH ||
                      (first && w[15:12] == `OFD_TOP_NIB);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_access;
    @(posedge clock_in) disable iff (!rst_b_in)
      first && !w[8] |=> access_ram_out && ram_bank_out == `OFD_BANK_RST;
  endproperty
  a_access: assert property (p_access) else $error("access RAM not forced");

  property p_bank;
    @(posedge clock_in) disable iff (!rst_b_in)
      first && w[8] |=> !access_ram_out && ram_bank_out == $past(bank_select_reg_q);
  endproperty
  a_bank: assert property (p_bank) else $error("bank not from bank select");

  property p_dest;
    @(posedge clock_in) disable iff (!rst_b_in)
      first |=> dest_file_out == $past(instr_word_in[9]);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_bit;
    @(posedge clock_in) disable iff (!rst_b_in)
      first |=> $onehot(bit_onehot_out) &&
                bit_onehot_out == (8'h01 << $past(instr_word_in[11:9]));
  endproperty
  a_bit: assert property (p_bit) else $error("bit select wrong");

  property p_move;
    @(posedge clock_in) disable iff (!rst_b_in)
      second |=> src_addr_out == $past(w1_q[11:0]) &&
                 dst_addr_out == $past(instr_word_in[11:0]);
  endproperty
  a_move: assert property (p_move) else $error("move addresses wrong");

  property p_nop;
    @(posedge clock_in) disable iff (!rst_b_in)
      first && w[15:12] == 4'hF |=> exec_nop_out && state_q == OFD_ST_SINGLE;
  endproperty
  a_nop: assert property (p_nop) else $error("lone second word not a no-op");

  property p_cycle;
    @(posedge clock_in) disable iff (!rst_b_in)
      q_en |=> !q_en [*3] ##1 q_en;
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle not four clocks");

  property p_fast;
    @(posedge clock_in) disable iff (!rst_b_in)
      first && (is_ret || is_call) |=>
        fast_out == $past(is_call ? instr_word_in[8] : instr_word_in[0]);
  endproperty
  a_fast: assert property (p_fast) else $error("fast bit wrong");

  property p_lit8;
    @(posedge clock_in) disable iff (!rst_b_in)
      first |=> lit8_out == $past(instr_word_in[7:0]) ##4 1'b1;
  endproperty
  a_lit8: assert property (p_lit8) else $error("literal wrong");

endmodule : ofd_decoder
`default_nettype wire

// ---- ofd_core_model.sv ----
// Fetch and datapath stand-in facing the operand decoder
// Assumes the decoder's cycle start pulse on the same clock
`timescale 1ns/1ps
`default_nettype none

module ofd_core_model (
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        cycle_start_in,
  input  wire logic [15:0] next_word_in,
  input  wire logic        next_valid_in,
  input  wire logic        next_taken_in,
  input  wire logic        ld_in,
  input  wire logic [4:0]  ld_flags_in,
  input  wire logic [15:0] ld_prod_in,
  output logic      [15:0] instr_word_out,
  output logic             instr_valid_out,
  output logic             taken_out,
  output logic             flags_we_out,
  output logic      [4:0]  flags_out,
  output logic             prod_we_out,
  output logic      [15:0] prod_out
);
  // ****************************************
  // Fetch: next word goes up after each cycle start
  // ****************************************
  // An idle fetch shows the inverse of the last word, never a stale copy
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      instr_word_out  <= 16'h0000;
      instr_valid_out <= 1'b0;
      taken_out       <= 1'b0;
    end else if (cycle_start_in) begin
      instr_word_out  <= next_valid_in ? next_word_in : ~instr_word_out;
      instr_valid_out <= next_valid_in;
      taken_out       <= next_taken_in;
    end
  end

  // ****************************************
  // Flag and product loads as one-cycle strobes
  // ****************************************
  always_ff @(posedge clock_in) begin
    flags_we_out <= rst_b_in && ld_in;
    prod_we_out  <= rst_b_in && ld_in;
    flags_out    <= ld_in ? ld_flags_in : ~flags_out;
    prod_out     <= ld_in ? ld_prod_in : ~prod_out;
  end
endmodule : ofd_core_model

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the operand decoder
// Assumes ofd_core_model supplies words and flag loads
`timescale 1ns/1ps
`default_nettype none
`include "ofd_regs.svh"

module tb_top;
  import ofd_pkg::*;
  typedef struct packed {logic [15:0] w; logic acc; logic dst; logic [7:0] oh;} ofd_row_t;
  localparam ofd_row_t ROWS [8] = '{
    '{16'h2412, 1'b1, 1'b0, 8'h00}, '{16'h27FF, 1'b0, 1'b1, 8'h00},
    '{16'h2500, 1'b0, 1'b0, 8'h00}, '{16'h2680, 1'b1, 1'b1, 8'h00},
    '{16'h8100, 1'b0, 1'b0, 8'h01}, '{16'h8634, 1'b1, 1'b0, 8'h08},
    '{16'h8E55, 1'b1, 1'b0, 8'h80}, '{16'h8BAA, 1'b0, 1'b0, 8'h20}};
  localparam logic [20:0] TA [4] = '{21'h1F_FFFF, 21'h1F_FFFF, 21'h1F_FFFF, 21'h00_0000};
  localparam logic [20:0] TP [4] = '{21'h1F_FFFF, 21'h00_0000, 21'h1F_FFFE, 21'h00_0000};
  logic        clock_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        nval = 1'b0;
  logic        ntk = 1'b0;
  logic        ld = 1'b0;
  logic [2:0]  adr = 3'h0;
  logic [3:0]  be = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic [15:0] nword = 16'h0000;
  logic [15:0] ldp = 16'h0000;
  logic [4:0]  ldf = 5'h00;
  logic [31:0] rdat, got;
  logic [15:0] iw, pv;
  logic [4:0]  fv, fl;
  logic        iv, tk, fwe, pwe, wq, cs, acc, dst, fast, nop;
  logic [3:0]  bank;
  logic [7:0]  fa, oh, l8, ph, pl;
  logic [1:0]  ps;
  logic [11:0] sa, da, l12;
  logic [6:0]  so, dof;
  logic [19:0] l20;
  logic [10:0] rel;
  logic [20:0] ta;
  int          mismatches = 0;
  int          num_checks = 0;

  always #20 clock_in = ~clock_in;

  ofd_decoder uut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .instr_word_in(iw),
    .instr_valid_in(iv), .taken_in(tk), .flags_we_in(fwe), .flags_in(fv),
    .prod_we_in(pwe), .prod_in(pv), .cycle_start_out(cs), .access_ram_out(acc),
    .ram_bank_out(bank), .file_addr_out(fa), .dest_file_out(dst), .bit_onehot_out(oh),
    .ptr_sel_out(ps), .src_addr_out(sa), .dst_addr_out(da), .src_off_out(so),
    .dst_off_out(dof), .lit8_out(l8), .lit12_out(l12), .lit20_out(l20),
    .rel_off_out(rel), .fast_out(fast), .exec_nop_out(nop), .tbl_addr_out(ta),
    .flags_out(fl), .product_high_byte_out(ph), .product_low_byte_out(pl));

  ofd_core_model dp (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .cycle_start_in(cs),
    .next_word_in(nword), .next_valid_in(nval), .next_taken_in(ntk), .ld_in(ld),
    .ld_flags_in(ldf), .ld_prod_in(ldp), .instr_word_out(iw), .instr_valid_out(iv),
    .taken_out(tk), .flags_we_out(fwe), .flags_out(fv), .prod_we_out(pwe),
    .prod_out(pv));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang_out();
    mismatches++;
    $display("wrong value handshake expected answer seen timeout");
    tally_and_finish();
  endtask : hang_out

  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int k;
    @(posedge clock_in);
    rd   <= ~w;
    wr   <= w;
    adr  <= a;
    wdat <= d;
    be   <= b;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
      if (k > 40) hang_out();
    end while (wq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wait_start(output int cyc);
    cyc = 0;
    do begin
      @(negedge clock_in);
      cyc++;
      if (cyc > 40) hang_out();
    end while (cs !== 1'b1);
  endtask : wait_start

  // Second word of zero means a single-word instruction
  task automatic issue(input logic [15:0] w1, input logic [15:0] w2, input logic t);
    int c;
    @(posedge clock_in);
    nword <= w1;
    nval  <= 1'b1;
    ntk   <= t;
    wait_start(c);
    @(posedge clock_in);
    nword <= w2;
    nval  <= (w2 != 16'h0000);
    ntk   <= 1'b0;
    wait_start(c);
    if (w2 != 16'h0000) begin
      @(posedge clock_in);
      nval <= 1'b0;
      wait_start(c);
    end
    chk("cycle length", 32'h4, 32'(c));
  endtask : issue

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int c;
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    chk("onehot at reset", 32'h1, 32'(oh));
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 3'(i), 32'h0, 4'hF);
      chk("reset register", 32'h0, got);
    end
    bus(1'b1, `OFD_REG_BANK, 32'hFFFF_FFF5, 4'hF);
    bus(1'b1, `OFD_REG_BANK, 32'h0000_000A, 4'h0);
    bus(1'b1, 3'h5, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 3'h5, 32'h0, 4'hF);
    chk("unmapped read", 32'h0, got);
    bus(1'b0, `OFD_REG_BANK, 32'h0, 4'hF);
    chk("bank register", 32'h5, got);
    $display("test registers done");
    foreach (ROWS[r]) begin
      issue(ROWS[r].w, 16'h0000, 1'b0);
      chk("access ram", 32'(ROWS[r].acc), 32'(acc));
      chk("bank", ROWS[r].acc ? 32'h0 : 32'h5, 32'(bank));
      chk("file address", 32'(ROWS[r].w[7:0]), 32'(fa));
      if (ROWS[r].oh != 8'h00) chk("bit select", 32'(ROWS[r].oh), 32'(oh));
      else chk("destination", 32'(ROWS[r].dst), 32'(dst));
      chk("no-op flag", 32'h0, 32'(nop));
    end
    $display("test byte and bit rows done");
    issue(16'hCFFF, 16'hF000, 1'b0);
    chk("move source", 32'h0000_0FFF, 32'(sa));
    chk("move dest", 32'h0, 32'(da));
    issue(16'hC123, 16'hF456, 1'b0);
    chk("move source", 32'h0000_0123, 32'(sa));
    chk("move dest", 32'h0000_0456, 32'(da));
    chk("source offset", 32'h0000_0023, 32'(so));
    chk("dest offset", 32'h0000_0056, 32'(dof));
    issue(16'hEF34, 16'hF12A, 1'b0);
    chk("long literal", 32'h0001_2A34, 32'(l20));
    issue(16'hEE35, 16'hF0AB, 1'b0);
    chk("pointer select", 32'h3, 32'(ps));
    chk("mid literal", 32'h0000_05AB, 32'(l12));
    issue(16'hED34, 16'hF000, 1'b0);
    chk("fast bit", 32'h1, 32'(fast));
    chk("call target", 32'h0000_0034, 32'(l20));
    issue(16'h0012, 16'h0000, 1'b0);
    chk("fast bit", 32'h0, 32'(fast));
    issue(16'h0013, 16'h0000, 1'b0);
    chk("fast bit", 32'h1, 32'(fast));
    issue(16'h0E7F, 16'h0000, 1'b0);
    chk("short literal", 32'h0000_007F, 32'(l8));
    issue(16'hD7FF, 16'h0000, 1'b0);
    chk("long offset", 32'h0000_07FF, 32'(rel));
    issue(16'hE280, 16'h0000, 1'b0);
    chk("short offset", 32'h0000_0780, 32'(rel));
    $display("test double words and literals done");
    issue(16'hF123, 16'h0000, 1'b0);
    chk("lone second word", 32'h1, 32'(nop));
    issue(16'hD400, 16'h0000, 1'b1);
    chk("taken offset", 32'h0000_0400, 32'(rel));
    wait_start(c);
    chk("flush cycle", 32'h1, 32'(nop));
    $display("test no-op cycles done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `OFD_REG_TABLE_POINTER, 32'h001F_FFFF, 4'hF);
      issue(16'h0008 | 16'(m), 16'h0000, 1'b0);
      repeat (2) @(negedge clock_in);
      chk("table address", 32'(TA[m]), 32'(ta));
      bus(1'b0, `OFD_REG_TABLE_POINTER, 32'h0, 4'hF);
      chk("table pointer", 32'(TP[m]), got);
    end
    $display("test table modes done");
    bus(1'b1, `OFD_REG_FLAGS, 32'hFFFF_FFF5, 4'hF);
    bus(1'b0, `OFD_REG_FLAGS, 32'h0, 4'hF);
    chk("flags register", 32'h0000_0015, got);
    @(posedge clock_in);
    ld  <= 1'b1;
    ldf <= 5'h0A;
    ldp <= 16'hBEEF;
    @(posedge clock_in);
    ld <= 1'b0;
    repeat (3) @(negedge clock_in);
    chk("flags", 32'h0000_000A, 32'(fl));
    chk("product high", 32'h0000_00BE, 32'(ph));
    chk("product low", 32'h0000_00EF, 32'(pl));
    bus(1'b0, `OFD_REG_PROD, 32'h0, 4'hF);
    chk("product register", 32'h0000_BEEF, got);
    $display("test flags and product done");
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    repeat (2) @(negedge clock_in);
    chk("onehot after reset", 32'h1, 32'(oh));
    chk("literal after reset", 32'h0, 32'(l20));
    chk("flags after reset", 32'h0, 32'(fl));
    chk("wait after reset", 32'h1, 32'(wq));
    @(posedge clock_in);
    rst_b_in <= 1'b1;
    bus(1'b0, `OFD_REG_BANK, 32'h0, 4'hF);
    chk("bank after reset", 32'h0, got);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
